// >>> rtl/timer_io_pkg.sv
// constants and types for the timer i/o control guard
`default_nettype none
package timer_io_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ctl_primary_offset = 3'h0;
  localparam logic [2:0] ctl_secondary_offset = 3'h1;
  localparam logic [2:0] output_ctl_offset = 3'h2;
  localparam logic [2:0] capture_ctl_offset = 3'h3;
  localparam logic [2:0] event_trig_ctl_offset = 3'h4;
  localparam logic [2:0] guard_status_offset = 3'h5;
  // field positions
  localparam int run_enable_pos = 7;
  localparam int ext_event_enable_pos = 5;
  localparam int output0_pin_enable_pos = 0;
  localparam int output0_level_select_pos = 1;
  localparam int output1_pin_enable_pos = 2;
  localparam int output1_level_select_pos = 3;
  // operating mode encodings
  localparam logic [2:0] mode_event_count = 3'h1;
  localparam logic [2:0] mode_ext_trigger_pulse = 3'h2;
  localparam logic [2:0] mode_one_shot_pulse = 3'h3;
  localparam logic [2:0] mode_free_running = 3'h5;
  localparam logic [2:0] mode_pulse_width = 3'h6;
  // edge select encodings
  localparam logic [1:0] edge_none = 2'h0;
  localparam logic [1:0] edge_rising = 2'h1;
  localparam logic [1:0] edge_falling = 2'h2;
  localparam logic [1:0] edge_both = 2'h3;
  // reset values
  localparam logic [7:0] reg_reset_value = 8'h00;
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage : timer_io_pkg
`default_nettype wire

// >>> rtl/edge_sense.sv
// synchronised edge detector with selectable edge
`default_nettype none
module edge_sense (
  input wire logic sys_clk, // 40 mhz clock
  input wire logic rst, // async reset, active high
  input wire logic pin, // raw pin from outside
  input wire logic [1:0] edge_select, // which edge counts
  output logic edge_seen // one-cycle pulse on chosen edge
);
  import timer_io_pkg::*;

  typedef struct packed {
    logic meta; // first sync stage, read only by stage two
    logic sync; // second sync stage
    logic prev; // sync delayed once for edge compare
  } edge_state_type;

  edge_state_type state;
  edge_state_type next_state;

  // shift pin through two stages, then keep one history bit
  always_comb begin
    next_state = state;
    next_state.meta = pin;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // edge decode works only on synchronised bits
  always_comb begin
    case (edge_select)
      edge_rising: edge_seen = state.sync & ~state.prev;
      edge_falling: edge_seen = ~state.sync & state.prev;
      edge_both: edge_seen = state.sync ^ state.prev;
      default: edge_seen = 1'b0; // no edge selected
    endcase
  end
endmodule : edge_sense
`default_nettype wire

// >>> rtl/timer_io_control_guard.sv
// timer i/o control registers, pin levels and gated edge inputs
//
// Function
// - output pin follows level select when idle
// - capture only in free-run or pulse-width mode
// - event edge used if enabled or mode 001
// - identical writes while running have no effect
// - trigger edge used only in modes 010/011
// - event count mode counts regardless of enable
//
// The address-and-strobe port and the placing of the registers were decided locally.
`default_nettype none
module timer_io_control_guard (
  input wire logic sys_clk, // 40 mhz clock
  input wire logic rst, // async reset, active high
  input wire timer_io_pkg::reg_req_type bus_req, // register request
  output logic [7:0] rdata, // read data, cycle after read strobe
  input wire logic [1:0] compare_toggle, // toggle requests from compare
  input wire logic [1:0] capture_pin, // capture input pins
  input wire logic event_pin, // external event input pin
  input wire logic trigger_pin, // external trigger input pin
  output logic [1:0] timer_output_pin, // timer output pin levels
  output logic [1:0] capture_strobe, // capture pulses to counter
  output logic event_strobe, // count pulse to counter
  output logic trigger_strobe, // trigger pulse to counter
  output logic timer_run_enable, // run enable to counter
  output logic [2:0] operating_mode // mode field to counter
);
  import timer_io_pkg::*;

  typedef struct packed {
    logic run; // timer run enable
    logic eee; // external event enable
    logic [2:0] mode; // operating mode select
    logic [3:0] out_ctl; // ol1 oe1 ol0 oe0
    logic [3:0] cap_ctl; // two edge selects for two captures
    logic [3:0] evt_ctl; // event edge hi/lo, trigger edge hi/lo
    logic violation; // a write tried to change a protected field while running
    logic [1:0] pin_level; // driven output levels
    logic [1:0] capture; // registered capture pulses
    logic event_p; // registered event pulse
    logic trigger_p; // registered trigger pulse
    logic [7:0] rdata; // registered read data
  } guard_state_type;

  guard_state_type state;
  guard_state_type next_state;
  logic [3:0] edge_raw; // capture0, capture1, event, trigger
  logic [3:0] raw_pins; // pins in the same order
  logic [7:0] edge_sel; // edge selects in the same order
  logic wr_changes; // protected write would alter a field

  assign raw_pins = {trigger_pin, event_pin, capture_pin};
  assign edge_sel = {state.evt_ctl[1:0], state.evt_ctl[3:2],
                     state.cap_ctl};

  // one synchronised edge detector per external input
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      edge_sense u_edge (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(raw_pins[gi]),
        .edge_select(edge_sel[2*gi +: 2]),
        .edge_seen(edge_raw[gi])
      );
    end
  endgenerate

  // does this write alter a protected field
  always_comb begin
    wr_changes = 1'b0;
    if (bus_req.addr == ctl_secondary_offset) begin
      wr_changes = ({bus_req.wdata[ext_event_enable_pos],
                     bus_req.wdata[2:0]} != {state.eee, state.mode});
    end else if (bus_req.addr == output_ctl_offset) begin
      wr_changes = (bus_req.wdata[3:0] != state.out_ctl);
    end else if (bus_req.addr == capture_ctl_offset) begin
      wr_changes = (bus_req.wdata[3:0] != state.cap_ctl);
    end else if (bus_req.addr == event_trig_ctl_offset) begin
      wr_changes = (bus_req.wdata[3:0] != state.evt_ctl);
    end
  end

  // next state: register writes, reads, pins and strobes
  always_comb begin
    next_state = state;
    // writes; running protects fields, identical writes pass silently
    if (bus_req.wr) begin
      if (state.run && wr_changes) begin
        next_state.violation = 1'b1;
      end else if (bus_req.addr == ctl_primary_offset) begin
        next_state.run = bus_req.wdata[run_enable_pos];
      end else if (bus_req.addr == ctl_secondary_offset) begin
        next_state.eee = bus_req.wdata[ext_event_enable_pos];
        next_state.mode = bus_req.wdata[2:0];
      end else if (bus_req.addr == output_ctl_offset) begin
        next_state.out_ctl = bus_req.wdata[3:0];
      end else if (bus_req.addr == capture_ctl_offset) begin
        next_state.cap_ctl = bus_req.wdata[3:0];
      end else if (bus_req.addr == event_trig_ctl_offset) begin
        next_state.evt_ctl = bus_req.wdata[3:0];
      end
      // stopping the timer starts the recovery, so flag clears
      if (bus_req.addr == ctl_primary_offset &&
          !bus_req.wdata[run_enable_pos]) begin
        next_state.violation = 1'b0;
      end
    end
    // read data only in the cycle after the strobe
    next_state.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == ctl_primary_offset) begin
        next_state.rdata = {state.run, 7'h00};
      end else if (bus_req.addr == ctl_secondary_offset) begin
        next_state.rdata = {2'h0, state.eee, 2'h0, state.mode};
      end else if (bus_req.addr == output_ctl_offset) begin
        next_state.rdata = {4'h0, state.out_ctl};
      end else if (bus_req.addr == capture_ctl_offset) begin
        next_state.rdata = {4'h0, state.cap_ctl};
      end else if (bus_req.addr == event_trig_ctl_offset) begin
        next_state.rdata = {4'h0, state.evt_ctl};
      end else if (bus_req.addr == guard_status_offset) begin
        next_state.rdata = {7'h00, state.violation};
      end
    end
    // pin level: idle follows level select, running toggles from it
    if (!(state.run && state.out_ctl[output0_pin_enable_pos])) begin
      next_state.pin_level[0] = state.out_ctl[output0_level_select_pos];
    end else if (compare_toggle[0]) begin
      next_state.pin_level[0] = ~state.pin_level[0];
    end
    if (!(state.run && state.out_ctl[output1_pin_enable_pos])) begin
      next_state.pin_level[1] = state.out_ctl[output1_level_select_pos];
    end else if (compare_toggle[1]) begin
      next_state.pin_level[1] = ~state.pin_level[1];
    end
    // capture only in the two measuring modes
    next_state.capture = 2'h0;
    if (state.run && (state.mode == mode_free_running ||
                      state.mode == mode_pulse_width)) begin
      next_state.capture = edge_raw[1:0];
    end
    // event mode counts even with the enable bit low
    next_state.event_p = state.run && edge_raw[2] &&
        (state.eee || state.mode == mode_event_count);
    // trigger only in the two triggered pulse modes
    next_state.trigger_p = state.run && edge_raw[3] &&
        (state.mode == mode_ext_trigger_pulse ||
         state.mode == mode_one_shot_pulse);
  end

  // single register stage for the whole block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign timer_output_pin = state.pin_level;
  assign capture_strobe = state.capture;
  assign event_strobe = state.event_p;
  assign trigger_strobe = state.trigger_p;
  assign timer_run_enable = state.run;
  assign operating_mode = state.mode;

  // idle output follows level select one cycle later
  a_idle_pin_level: assert property (@(posedge sys_clk)
    disable iff (rst)
    !(state.run && state.out_ctl[output0_pin_enable_pos])
    |=> timer_output_pin[0] == $past(state.out_ctl[output0_level_select_pos]))
    else $error("idle output 0 does not follow level select");

  // second output obeys the same idle rule on its own bits
  a_idle_pin_one: assert property (@(posedge sys_clk)
    disable iff (rst)
    !(state.run && state.out_ctl[output1_pin_enable_pos])
    |=> timer_output_pin[1] == $past(state.out_ctl[output1_level_select_pos]))
    else $error("idle output 1 does not follow level select");

  // capture pulses only in measuring modes
  a_capture_mode_gate: assert property (@(posedge sys_clk)
    disable iff (rst)
    (capture_strobe != 2'h0) |-> ($past(state.mode) == mode_free_running ||
                                  $past(state.mode) == mode_pulse_width))
    else $error("capture outside measuring modes");

  // event edge only when enabled or in count mode
  a_event_gate: assert property (@(posedge sys_clk)
    disable iff (rst)
    event_strobe |-> ($past(state.eee) ||
                      $past(state.mode) == mode_event_count))
    else $error("event pulse without enable or count mode");

  // count mode passes edges with enable low
  a_event_count_mode: assert property (@(posedge sys_clk)
    disable iff (rst)
    (state.run && state.mode == mode_event_count && edge_raw[2])
    |=> event_strobe)
    else $error("event count mode dropped an edge");

  // trigger only in pulse modes
  a_trigger_gate: assert property (@(posedge sys_clk)
    disable iff (rst)
    trigger_strobe |-> ($past(state.mode) == mode_ext_trigger_pulse ||
                        $past(state.mode) == mode_one_shot_pulse))
    else $error("trigger outside pulse modes");

  // identical writes while running leave everything unchanged
  a_same_write_quiet: assert property (@(posedge sys_clk)
    disable iff (rst)
    (bus_req.wr && state.run && !wr_changes &&
     bus_req.addr != ctl_primary_offset)
    |=> $stable(state.out_ctl) && $stable(state.cap_ctl) &&
        $stable(state.evt_ctl) && $stable(state.mode) &&
        $stable(state.violation))
    else $error("identical write while running had an effect");

  // a changed write while running is dropped whole and flagged;
  // dropping keeps a running counter from seeing a half-applied setup
  a_changed_write_dropped: assert property (@(posedge sys_clk)
    disable iff (rst)
    (bus_req.wr && state.run && wr_changes)
    |=> $stable(state.out_ctl) && $stable(state.cap_ctl) &&
        $stable(state.evt_ctl) && $stable(state.mode) &&
        $stable(state.eee) && state.violation)
    else $error("changed write while running was not dropped");
endmodule : timer_io_control_guard
`default_nettype wire

// >>> test/test_timer_io_control_guard.sv
// self-checking bench for the timer i/o control guard
`default_nettype none
module test_timer_io_control_guard;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_io_pkg::*;
  logic sys_clk; // 40 mhz bench clock
  logic rst; // async reset, active high
  reg_req_type bus_req; // register port request
  logic [7:0] rdata; // register read data
  logic [1:0] compare_toggle; // toggle requests
  logic [1:0] capture_pin; // capture inputs
  logic event_pin; // external event input
  logic trigger_pin; // external trigger input
  logic [1:0] timer_output_pin; // pin levels seen
  logic [1:0] capture_strobe; // capture pulses seen
  logic event_strobe; // count pulses seen
  logic trigger_strobe; // trigger pulses seen
  logic timer_run_enable; // run level seen
  logic [2:0] operating_mode; // mode field seen
  int n_fail = 0; // mismatches
  int samples_checked = 0; // comparisons made

  timer_io_control_guard dut_u (
    .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .compare_toggle(compare_toggle), .capture_pin(capture_pin),
    .event_pin(event_pin), .trigger_pin(trigger_pin),
    .timer_output_pin(timer_output_pin), .capture_strobe(capture_strobe),
    .event_strobe(event_strobe), .trigger_strobe(trigger_strobe),
    .timer_run_enable(timer_run_enable), .operating_mode(operating_mode)
  );

  // free-running clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  // one comparison, reported at once on mismatch
  task automatic chk(input string nm, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // single-cycle register write; waits an edge first so strobes never merge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // single-cycle read; data stands only in the following cycle
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rd_chk

  // configure stopped, start, raise one pin, drop it, count strobes
  task automatic edge_chk(input logic [7:0] c1, input logic [2:0] a,
                          input logic [7:0] sel, input int kind,
                          input logic [7:0] exp);
    logic [7:0] n;
    logic [3:0] seen; // capture0, event, trigger, capture1 strobes
    n = 8'h00;
    seen = 4'h0;
    wr(3'h0, 8'h00);
    wr(3'h1, c1);
    wr(a, sel);
    wr(3'h0, 8'h80);
    repeat (4) @(posedge sys_clk); // sync history must fill first
    case (kind)
      0: capture_pin <= 2'b01;
      1: event_pin <= 1'b1;
      2: trigger_pin <= 1'b1;
      default: capture_pin <= 2'b10;
    endcase
    // rising edge counted in the first eight cycles, falling in the rest
    for (int c = 0; c < 17; c++) begin
      @(posedge sys_clk);
      if (c == 8) begin
        capture_pin <= 2'b00;
        event_pin <= 1'b0;
        trigger_pin <= 1'b0;
      end
      #1;
      if (c == 0) begin
        chk("run", 8'h01, {7'h00, timer_run_enable});
        chk("mode", {5'h00, c1[2:0]}, {5'h00, operating_mode});
      end
      seen = {capture_strobe[1], trigger_strobe, event_strobe,
              capture_strobe[0]};
      if (seen[kind] === 1'b1)
        n++;
    end
    chk("strobe count", exp, n);
  endtask : edge_chk

  // verdict and end of run, shared with the watchdog
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // hang guard, far beyond the roughly 380 cycles the run needs
  initial begin
    #(20000 * 25);
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bus_req = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    compare_toggle = 2'b00;
    capture_pin = 2'b00;
    event_pin = 1'b0;
    trigger_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values, index 6 is unmapped
    for (int i = 0; i < 7; i++) rd_chk(3'(i), reg_reset_value);
    // level select drives the pin while stopped and disabled
    wr(output_ctl_offset, 8'h02);
    @(posedge sys_clk);
    #1 chk("pin", 8'h01, {6'h00, timer_output_pin});
    wr(output_ctl_offset, 8'h0a);
    @(posedge sys_clk);
    #1 chk("pin", 8'h03, {6'h00, timer_output_pin});
    wr(output_ctl_offset, 8'h01);
    wr(ctl_primary_offset, 8'h80);
    // identical write while running is silent
    wr(output_ctl_offset, 8'h01);
    rd_chk(guard_status_offset, 8'h00);
    // compare toggle reaches an enabled pin while running
    @(posedge sys_clk);
    compare_toggle <= 2'b01;
    @(posedge sys_clk);
    compare_toggle <= 2'b00;
    @(posedge sys_clk);
    #1 chk("pin toggle", 8'h01, {7'h00, timer_output_pin[0]});
    // changed writes while running are dropped and flagged
    wr(output_ctl_offset, 8'h03);
    rd_chk(output_ctl_offset, 8'h01);
    rd_chk(guard_status_offset, 8'h01);
    wr(capture_ctl_offset, 8'h01);
    rd_chk(capture_ctl_offset, 8'h00);
    wr(event_trig_ctl_offset, 8'h04);
    rd_chk(event_trig_ctl_offset, 8'h00);
    // recovery: stop first, then rewrite
    wr(ctl_primary_offset, 8'h00);
    rd_chk(guard_status_offset, 8'h00);
    wr(output_ctl_offset, 8'h03);
    rd_chk(output_ctl_offset, 8'h03);
    // edge gating per mode and enable
    edge_chk(8'h01, event_trig_ctl_offset, 8'h04, 1, 8'h01);
    edge_chk(8'h05, event_trig_ctl_offset, 8'h04, 1, 8'h00);
    edge_chk(8'h25, event_trig_ctl_offset, 8'h04, 1, 8'h01);
    edge_chk(8'h05, capture_ctl_offset, 8'h01, 0, 8'h01);
    edge_chk(8'h06, capture_ctl_offset, 8'h01, 0, 8'h01);
    edge_chk(8'h01, capture_ctl_offset, 8'h01, 0, 8'h00);
    edge_chk(8'h02, event_trig_ctl_offset, 8'h01, 2, 8'h01);
    edge_chk(8'h03, event_trig_ctl_offset, 8'h01, 2, 8'h01);
    edge_chk(8'h05, event_trig_ctl_offset, 8'h01, 2, 8'h00);
    // second capture input: falling only, then both edges
    edge_chk(8'h05, capture_ctl_offset, 8'h08, 3, 8'h01);
    edge_chk(8'h06, capture_ctl_offset, 8'h0c, 3, 8'h02);
    summarize();
  end
endmodule : test_timer_io_control_guard
`default_nettype wire
